//--- rtl/trc_pkg.sv
// package: constants, formats and types of the tiny risc core
package trc_pkg;
  // widths and sizes
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned MSB_B       = DATA_W - 1;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned REG_COUNT   = 32;
  localparam int unsigned REG_AW      = 5;
  localparam int unsigned PC_W        = 9;
  localparam int unsigned INSN_W      = 16;
  localparam int unsigned IO_AW       = 6;
  localparam int unsigned STACK_DEPTH = 3;
  localparam int unsigned IRQ_N       = 5;
  localparam int unsigned IRQ_IW      = 3;

  // addresses and reset values
  localparam logic [PC_W-1:0]   RESET_VEC    = 9'h000;
  localparam logic [PC_W-1:0]   IRQ_VEC_BASE = 9'h001;
  localparam logic [PC_W-1:0]   PC_STEP      = 9'h001;
  localparam logic [REG_AW-1:0] ZL_IDX       = 5'h1e;
  localparam logic [REG_AW-1:0] ZH_IDX       = 5'h1f;
  localparam logic [REG_AW-1:0] LPM_DST      = 5'h00;
  localparam logic              UPPER_HALF   = 1'h1;
  localparam logic [IO_AW-1:0]  IO_STATUS    = 6'h3f;
  localparam logic [DATA_W-1:0] STATUS_FLAGS_REG_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] SIGN_MIN     = 8'h80;
  localparam logic [DATA_W-1:0] SIGN_MAX     = 8'h7f;
  localparam logic [DATA_W-1:0] ONE_B        = 8'h01;

  // status flag bit positions
  localparam int unsigned FLAG_I = 7;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_C = 0;

  // alu operation groups
  localparam logic [1:0] GRP_ARITH = 2'h0;
  localparam logic [1:0] GRP_LOGIC = 2'h1;
  localparam logic       GRP_ONE   = 1'h1;

  typedef enum logic [3:0] {
    OPC_ARITH, OPC_LOGIC, OPC_SINGLE, OPC_SUBTRACT_IMMEDIATE, OPC_SUB_CARRY_IMMEDIATE, OPC_CPI, OPC_BITWISE_AND_WITH_CONSTANT,
    OPC_ORI, OPC_LDI, OPC_IO, OPC_RJMP, OPC_RELATIVE_CALL, OPC_MISC
  } trc_opc_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_MOV,
    ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ROR, ALU_ASR, ALU_SWAP
  } trc_alu_t;

  typedef enum logic [3:0] {
    MISC_NOP, MISC_RET, MISC_INTERRUPT_EXIT, MISC_LPM, MISC_LDZ, MISC_STZ, MISC_SEI, MISC_CLI
  } trc_misc_t;

  typedef enum logic [1:0] {ST_RUN, ST_LPM_ADDR, ST_LPM_DATA, ST_IN_DATA} trc_state_t;

  // instruction word formats, all one 16-bit word
  typedef struct packed {logic [3:0] opc; logic [1:0] sub; logic [4:0] rd; logic [4:0] rr;}
    trc_fmt_rr_t;
  typedef struct packed {logic [3:0] opc; logic [3:0] rd; logic [7:0] k;} trc_fmt_imm_t;
  typedef struct packed {logic [3:0] opc; logic out; logic [4:0] rd; logic [5:0] a;}
    trc_fmt_io_t;
  typedef struct packed {logic [3:0] opc; logic [11:0] k;} trc_fmt_rel_t;
  typedef struct packed {logic [3:0] opc; logic [3:0] rsv; logic [4:0] rd; logic [2:0] f;}
    trc_fmt_one_t;
  typedef struct packed {logic [3:0] opc; logic [2:0] rsv; logic [4:0] rd; logic [3:0] sub;}
    trc_fmt_misc_t;

  // i/o space request and alu result
  typedef struct packed {
    logic [IO_AW-1:0]  addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } trc_io_req_t;
  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic              c;
    logic              z;
    logic              n;
    logic              v;
    logic              h;
  } trc_alu_out_t;
endpackage : trc_pkg

//--- rtl/trc_stack.sv
// three level hardware return stack of the tiny risc core
`timescale 1ns/10ps
module trc_stack import trc_pkg::*; (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // push and pop requests
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] push_pc,
  // level 0
  output logic      [PC_W-1:0] top
);
  logic [PC_W-1:0] lvl [STACK_DEPTH];

  genvar i;
  for (i = 0; i < STACK_DEPTH; i++) begin : g_lvl
    logic [PC_W-1:0] below;
    logic [PC_W-1:0] above;
    if (i == 0) begin : g_first
      assign above = push_pc;
    end else begin : g_mid
      assign above = lvl[i-1];
    end
    if (i == STACK_DEPTH - 1) begin : g_last
      assign below = lvl[i];
    end else begin : g_up
      assign below = lvl[i+1];
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        lvl[i] <= RESET_VEC;
      end else if (push) begin
        lvl[i] <= above;
      end else if (pop) begin
        lvl[i] <= below;
      end
    end
  end

  assign top = lvl[0];

  // checks on the stack shifting
  a_push_shift: assert property (@(posedge clk) disable iff (!rstn)
    push |=> lvl[0] == $past(push_pc) && lvl[1] == $past(lvl[0]) && lvl[2] == $past(lvl[1]))
    else $error("push did not shift the stack down");
  a_pop_shift: assert property (@(posedge clk) disable iff (!rstn)
    pop && !push |=> lvl[0] == $past(lvl[1]) && lvl[1] == $past(lvl[2]))
    else $error("pop did not shift the stack up");
  a_deep_keep: assert property (@(posedge clk) disable iff (!rstn)
    pop && !push |=> lvl[2] == $past(lvl[2]))
    else $error("deepest level lost on pop");
  c_push_pop: cover property (@(posedge clk) disable iff (!rstn) push ##[1:20] pop);
endmodule : trc_stack

//--- rtl/trc_core.sv
// execution core of the tiny risc microcontroller
// Functional notes
// - thirty-two eight-bit registers, single-cycle access
// - read two operands, compute, write back
// - alu on two registers, constant, one
// - constant operand instructions use registers 16-31
// - registers 30 and 31 form pointer
// - register indirect uses low pointer byte only
// - two-register result goes to destination
// - fetch next word while current executes
// - each program word is one instruction
// - nine-bit program counter, 512 words
// - relative target is pc plus offset plus one
// - pointer word address, bit zero selects byte
// - io instructions carry six-bit address
// - three level nine-bit return stack
// - call or interrupt pushes level zero
// - return pops level zero, shifts up
// - fourth push loses the oldest entry
// - lower vector interrupt wins
// - runs on system clock, no division
// - reset starts fetch at address zero
// - interrupt clears global enable, interrupt return sets, plain return leaves it
// - status flags not saved on interrupt
`timescale 1ns/10ps
module trc_core import trc_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // program memory, synchronous read
  output logic      [PC_W-1:0]   pmem_addr,
  input  wire logic [INSN_W-1:0] pmem_rdata,
  // i/o space
  output trc_io_req_t            io_req,
  input  wire logic [DATA_W-1:0] io_rdata,
  // interrupts and status
  input  wire logic [IRQ_N-1:0]  irq_req,
  output logic      [IRQ_N-1:0]  irq_ack,
  output logic      [DATA_W-1:0] status_flags_reg
);
  logic [DATA_W-1:0] rf [REG_COUNT];
  trc_state_t        state;
  trc_state_t        next_state;
  logic              fetch_ok;
  logic [PC_W-1:0]   exec_pc;
  logic [REG_AW-1:0] pend_rd;
  logic [DATA_W-1:0] next_status_flags_reg;
  logic [PC_W-1:0]   next_pc;
  logic [PC_W-1:0]   stk_top;

  // every word decodes as one instruction
  trc_fmt_rr_t   f_rr;
  trc_fmt_imm_t  f_imm;
  trc_fmt_io_t   f_io;
  trc_fmt_rel_t  f_rel;
  trc_fmt_one_t  f_one;
  trc_fmt_misc_t f_misc;
  assign f_rr   = pmem_rdata;
  assign f_imm  = pmem_rdata;
  assign f_io   = pmem_rdata;
  assign f_rel  = pmem_rdata;
  assign f_one  = pmem_rdata;
  assign f_misc = pmem_rdata;

  // pointer, interrupt selection and execute qualifiers
  logic [INSN_W-1:0] zptr;
  logic [IRQ_IW-1:0] irq_sel;
  logic              run_ok;
  logic              irq_hit;
  logic              exec;
  // pointer from registers 30 and 31
  assign zptr    = {rf[ZH_IDX], rf[ZL_IDX]};
  assign run_ok  = (state == ST_RUN) && fetch_ok;
  assign irq_hit = run_ok && (|irq_req) && status_flags_reg[FLAG_I];
  assign exec    = run_ok && !irq_hit;

  always_comb begin
    irq_sel = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_sel = IRQ_IW'(i);
      end
    end
  end

  // alu with flag generation
  function automatic trc_alu_out_t alu_f(input trc_alu_t op, input logic [DATA_W-1:0] a,
                                         input logic [DATA_W-1:0] b,
                                         input logic [DATA_W-1:0] fl);
    trc_alu_out_t     o;
    logic [DATA_W:0]  s;
    logic [NIB_W:0]   hs;
    logic             cy;
    cy    = fl[FLAG_C] && (op == ALU_ADC || op == ALU_SBC);
    o.res = b;
    o.c   = fl[FLAG_C];
    o.h   = fl[FLAG_H];
    o.v   = fl[FLAG_V];
    o.z   = 1'b0;
    o.n   = 1'b0;
    case (op)
      ALU_ADD, ALU_ADC: begin
        s     = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cy};
        hs    = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {{NIB_W{1'b0}}, cy};
        o.res = s[DATA_W-1:0];
        o.c   = s[DATA_W];
        o.h   = hs[NIB_W];
        o.v   = (a[MSB_B] == b[MSB_B]) && (o.res[MSB_B] != a[MSB_B]);
      end
      ALU_SUB, ALU_SBC: begin
        s     = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, cy};
        hs    = {1'b0, a[NIB_W-1:0]} - {1'b0, b[NIB_W-1:0]} - {{NIB_W{1'b0}}, cy};
        o.res = s[DATA_W-1:0];
        o.c   = s[DATA_W];
        o.h   = hs[NIB_W];
        o.v   = (a[MSB_B] != b[MSB_B]) && (o.res[MSB_B] != a[MSB_B]);
      end
      ALU_AND: begin o.res = a & b; o.v = 1'b0; end
      ALU_OR:  begin o.res = a | b; o.v = 1'b0; end
      ALU_EOR: begin o.res = a ^ b; o.v = 1'b0; end
      ALU_COM: begin o.res = ~a; o.c = 1'b1; o.v = 1'b0; end
      ALU_NEG: begin
        o.res = REG_RESET - a;
        o.c   = (o.res != REG_RESET);
        o.v   = (o.res == SIGN_MIN);
      end
      ALU_INC: begin o.res = a + ONE_B; o.v = (o.res == SIGN_MIN); end
      ALU_DEC: begin o.res = a - ONE_B; o.v = (o.res == SIGN_MAX); end
      ALU_LSR, ALU_ROR, ALU_ASR: begin
        o.res = {(op == ALU_ROR) ? fl[FLAG_C] : (op == ALU_ASR) && a[MSB_B], a[MSB_B:1]};
        o.c   = a[0];
        o.v   = o.res[MSB_B] ^ a[0];
      end
      ALU_SWAP: o.res = {a[NIB_W-1:0], a[DATA_W-1:NIB_W]};
      default:  o.res = b;
    endcase
    o.z = (o.res == REG_RESET);
    o.n = o.res[MSB_B];
    return o;
  endfunction : alu_f

  // decoded controls
  trc_alu_t          alu_op;
  logic [REG_AW-1:0] dst_idx;
  logic              use_k;
  logic              alu_wr;
  logic              upd_flags;
  logic              do_jump;
  logic              do_call;
  logic              do_ret;
  logic              set_i;
  logic              clr_i;
  logic              go_lpm;
  logic              go_in;
  logic              do_out;
  logic              ind_rd;
  logic              ind_wr;

  // instruction decode
  always_comb begin
    alu_op    = ALU_MOV;
    dst_idx   = f_rr.rd;
    use_k     = 1'b0;
    alu_wr    = 1'b0;
    upd_flags = 1'b0;
    do_jump   = 1'b0;
    do_call   = 1'b0;
    do_ret    = 1'b0;
    set_i     = 1'b0;
    clr_i     = 1'b0;
    go_lpm    = 1'b0;
    go_in     = 1'b0;
    do_out    = 1'b0;
    ind_rd    = 1'b0;
    ind_wr    = 1'b0;
    if (exec) begin
      case (trc_opc_t'(f_rr.opc))
        OPC_ARITH: begin
          alu_op    = trc_alu_t'({GRP_ARITH, f_rr.sub});
          alu_wr    = 1'b1;
          upd_flags = 1'b1;
        end
        OPC_LOGIC: begin
          alu_op    = trc_alu_t'({GRP_LOGIC, f_rr.sub});
          alu_wr    = 1'b1;
          upd_flags = (alu_op != ALU_MOV);
        end
        OPC_SINGLE: begin
          dst_idx   = f_one.rd;
          alu_op    = trc_alu_t'({GRP_ONE, f_one.f});
          alu_wr    = 1'b1;
          upd_flags = (alu_op != ALU_SWAP);
        end
        // constant forms reach upper half only
        OPC_SUBTRACT_IMMEDIATE, OPC_SUB_CARRY_IMMEDIATE, OPC_CPI, OPC_BITWISE_AND_WITH_CONSTANT, OPC_ORI, OPC_LDI: begin
          dst_idx   = {UPPER_HALF, f_imm.rd};
          use_k     = 1'b1;
          alu_wr    = (f_imm.opc != OPC_CPI);
          upd_flags = (f_imm.opc != OPC_LDI);
          case (trc_opc_t'(f_imm.opc))
            OPC_SUBTRACT_IMMEDIATE: alu_op = ALU_SUB;
            OPC_SUB_CARRY_IMMEDIATE: alu_op = ALU_SBC;
            OPC_CPI:  alu_op = ALU_SUB;
            OPC_BITWISE_AND_WITH_CONSTANT: alu_op = ALU_AND;
            OPC_ORI:  alu_op = ALU_OR;
            default:  alu_op = ALU_MOV;
          endcase
        end
        // six-bit io address in the word
        OPC_IO: begin
          do_out = f_io.out;
          go_in  = !f_io.out;
        end
        OPC_RJMP:  do_jump = 1'b1;
        OPC_RELATIVE_CALL: begin
          do_jump = 1'b1;
          do_call = 1'b1;
        end
        OPC_MISC: begin
          case (trc_misc_t'(f_misc.sub))
            MISC_RET:  do_ret = 1'b1;
            MISC_INTERRUPT_EXIT: begin
              do_ret = 1'b1;
              set_i  = 1'b1;
            end
            MISC_LPM:  go_lpm = 1'b1;
            MISC_LDZ:  ind_rd = 1'b1;
            MISC_STZ:  ind_wr = 1'b1;
            MISC_SEI:  set_i  = 1'b1;
            MISC_CLI:  clr_i  = 1'b1;
            default:   set_i  = 1'b0;
          endcase
        end
        default: alu_wr = 1'b0;
      endcase
    end
  end

  // operands, alu and result in one cycle
  trc_alu_out_t      alu_o;
  logic [DATA_W-1:0] b_val;
  logic [REG_AW-1:0] ind_idx;
  logic              lpm_hi;
  logic              rf_we;
  logic [REG_AW-1:0] rf_wa;
  logic [DATA_W-1:0] rf_wd;
  logic [DATA_W-1:0] in_val;
  assign b_val   = use_k ? f_imm.k : rf[f_rr.rr];
  assign alu_o   = alu_f(alu_op, rf[dst_idx], b_val, status_flags_reg);
  // high pointer byte ignored for registers
  assign ind_idx = zptr[REG_AW-1:0];
  // pointer bit zero picks the byte
  assign lpm_hi  = zptr[0];
  assign in_val  = (io_req.addr == IO_STATUS) ? status_flags_reg : io_rdata;
  assign rf_we   = alu_wr || ind_rd || ind_wr || state == ST_LPM_DATA || state == ST_IN_DATA;
  assign rf_wa   = (state == ST_LPM_DATA) ? LPM_DST :
                   (state == ST_IN_DATA)  ? pend_rd :
                   ind_rd ? f_misc.rd : ind_wr ? ind_idx : dst_idx;
  assign rf_wd   = (state == ST_LPM_DATA) ? (lpm_hi ? pmem_rdata[INSN_W-1:DATA_W]
                                                   : pmem_rdata[DATA_W-1:0]) :
                   (state == ST_IN_DATA)  ? in_val :
                   ind_rd ? rf[ind_idx] : ind_wr ? rf[f_misc.rd] : alu_o.res;

  genvar g;
  for (g = 0; g < REG_COUNT; g++) begin : g_rf
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rf[g] <= REG_RESET;
      end else if (rf_we && rf_wa == REG_AW'(g)) begin
        rf[g] <= rf_wd;
      end
    end
  end

  // flow control targets
  logic [PC_W-1:0] rel_tgt;
  logic [PC_W-1:0] irq_vec;
  logic            redirect;
  logic            advance;
  // target is pc plus offset plus one
  assign rel_tgt  = exec_pc + f_rel.k[PC_W-1:0] + PC_STEP;
  assign irq_vec  = IRQ_VEC_BASE + {{(PC_W-IRQ_IW){1'b0}}, irq_sel};
  assign redirect = irq_hit || do_jump || do_ret;
  assign advance  = (state == ST_RUN && !redirect && !go_lpm && !go_in) ||
                    state == ST_LPM_DATA || state == ST_IN_DATA;

  assign next_pc = irq_hit ? irq_vec : do_ret ? stk_top : do_jump ? rel_tgt :
                   go_lpm ? zptr[PC_W:1] :
                   (state == ST_LPM_ADDR) ? exec_pc + PC_STEP :
                   advance ? pmem_addr + PC_STEP : pmem_addr;
  assign next_state = go_lpm ? ST_LPM_ADDR : go_in ? ST_IN_DATA :
                      (state == ST_LPM_ADDR) ? ST_LPM_DATA :
                      (state == ST_RUN) ? ST_RUN : ST_RUN;

  // fetch of next word overlaps execute
  // one step per system clock edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state     <= ST_RUN;
      pmem_addr <= RESET_VEC;
      exec_pc   <= RESET_VEC;
      fetch_ok  <= 1'b0;
    end else begin
      state     <= next_state;
      pmem_addr <= next_pc;
      fetch_ok  <= advance;
      exec_pc   <= advance ? pmem_addr : exec_pc;
    end
  end

  // return stack, pushed by call or interrupt
  // return address is next or interrupted word
  trc_stack u_stack (
    .clk     (clk),
    .rstn    (rstn),
    .push    (do_call || irq_hit),
    .pop     (do_ret),
    .push_pc (irq_hit ? exec_pc : exec_pc + PC_STEP),
    .top     (stk_top)
  );

  // other flags left untouched on entry
  always_comb begin
    next_status_flags_reg = status_flags_reg;
    if (upd_flags) begin
      next_status_flags_reg[FLAG_H] = alu_o.h;
      next_status_flags_reg[FLAG_S] = alu_o.n ^ alu_o.v;
      next_status_flags_reg[FLAG_V] = alu_o.v;
      next_status_flags_reg[FLAG_N] = alu_o.n;
      next_status_flags_reg[FLAG_Z] = alu_o.z;
      next_status_flags_reg[FLAG_C] = alu_o.c;
    end
    if (do_out && f_io.a == IO_STATUS) begin
      next_status_flags_reg = rf[f_io.rd];
    end
    if (set_i) begin
      next_status_flags_reg[FLAG_I] = 1'b1;
    end
    if (clr_i || irq_hit) begin
      next_status_flags_reg[FLAG_I] = 1'b0;
    end
  end

  // status, io request and interrupt acknowledge registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_flags_reg <= STATUS_FLAGS_REG_RESET;
      io_req           <= '0;
      pend_rd          <= LPM_DST;
      irq_ack          <= '0;
    end else begin
      status_flags_reg <= next_status_flags_reg;
      io_req.re        <= go_in;
      io_req.we        <= do_out && f_io.a != IO_STATUS;
      io_req.addr      <= (go_in || do_out) ? f_io.a : io_req.addr;
      io_req.wdata     <= do_out ? rf[f_io.rd] : io_req.wdata;
      pend_rd          <= go_in ? f_io.rd : pend_rd;
      irq_ack          <= irq_hit ? IRQ_N'(1) << irq_sel : '0;
    end
  end

  // checks
  a_reset_vector: assert property (@(posedge clk) $rose(rstn) |-> pmem_addr == RESET_VEC)
    else $error("fetch did not start at reset vector");
  a_rel_target: assert property (@(posedge clk) disable iff (!rstn)
    exec && do_jump |=> pmem_addr == $past(exec_pc) + $past(f_rel.k[PC_W-1:0]) + PC_STEP)
    else $error("relative target wrong");
  a_upper_half: assert property (@(posedge clk) disable iff (!rstn)
    use_k |-> dst_idx[REG_AW-1] == UPPER_HALF)
    else $error("constant form reached lower half");
  a_write_back: assert property (@(posedge clk) disable iff (!rstn)
    alu_wr |=> rf[$past(dst_idx)] == $past(alu_o.res))
    else $error("alu result not written back");
  a_irq_clears_i: assert property (@(posedge clk) disable iff (!rstn)
    irq_hit |=> !status_flags_reg[FLAG_I] && pmem_addr == $past(irq_vec) && !fetch_ok)
    else $error("interrupt entry wrong");
  a_irq_prio: assert property (@(posedge clk) disable iff (!rstn)
    irq_hit |=> irq_ack != '0 && ((irq_ack - IRQ_N'(1)) & $past(irq_req)) == '0)
    else $error("lower vector request did not win");
  a_flags_kept: assert property (@(posedge clk) disable iff (!rstn)
    irq_hit |=> status_flags_reg[FLAG_T:0] == $past(status_flags_reg[FLAG_T:0]))
    else $error("flags changed on interrupt entry");
  a_lpm_byte: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_LPM_DATA |=> rf[LPM_DST] == ($past(lpm_hi) ? $past(pmem_rdata[INSN_W-1:DATA_W])
                                                       : $past(pmem_rdata[DATA_W-1:0])))
    else $error("constant load took wrong byte");
  a_pipe_overlap: assert property (@(posedge clk) disable iff (!rstn)
    advance |=> exec_pc == $past(pmem_addr) && fetch_ok)
    else $error("fetch and execute out of step");
  c_irq_taken: cover property (@(posedge clk) disable iff (!rstn) irq_hit);
  c_call_ret: cover property (@(posedge clk) disable iff (!rstn) do_call ##[2:30] do_ret);
  c_lpm_done: cover property (@(posedge clk) disable iff (!rstn) state == ST_LPM_DATA);
  c_io_in: cover property (@(posedge clk) disable iff (!rstn) state == ST_IN_DATA);
endmodule : trc_core

//--- tb/trc_mem_model.sv
// program memory and i/o space model facing the core
`timescale 1ns/10ps
module trc_mem_model import trc_pkg::*; (
  // clock
  input  wire logic              clk,
  // program memory
  input  wire logic [PC_W-1:0]   pmem_addr,
  output logic      [INSN_W-1:0] pmem_rdata,
  // i/o space
  input  wire trc_io_req_t       io_req,
  output logic      [DATA_W-1:0] io_rdata
);
  logic [INSN_W-1:0] mem [512];
  logic [DATA_W-1:0] io_space [64];
  always @(posedge clk) pmem_rdata <= mem[pmem_addr];
  always @(posedge clk) if (io_req.we) io_space[io_req.addr] <= io_req.wdata;
  assign io_rdata = io_req.re ? io_space[io_req.addr] : ~io_space[io_req.addr];
endmodule : trc_mem_model

//--- tb/tb_top.sv
// self-checking bench of the tiny risc core
`timescale 1ns/10ps
module tb_top import trc_pkg::*;;
  typedef struct packed {logic [3:0] opc; logic [1:0] sub; logic [23:0] abr;} trc_tb_row_t;
  // operation, operand a, operand b, result
  localparam trc_tb_row_t ROWS [6] = '{'{4'h0, 2'h0, 24'h7f0180}, '{4'h0, 2'h2, 24'h1020f0},
    '{4'h1, 2'h0, 24'hccaa88}, '{4'h1, 2'h1, 24'hcc33ff}, '{4'h1, 2'h2, 24'hff0ff0},
    '{4'h1, 2'h3, 24'h005c5c}};
  logic              clk;
  logic              rstn;
  logic [PC_W-1:0]   pmem_addr;
  logic [INSN_W-1:0] pmem_rdata;
  trc_io_req_t       io_req;
  logic [DATA_W-1:0] io_rdata;
  logic [IRQ_N-1:0]  irq_req;
  logic [IRQ_N-1:0]  irq_ack;
  logic [DATA_W-1:0] status_flags_reg;
  logic [PC_W-1:0]   pc;
  logic [13:0]       wq [$];
  logic [13:0]       eq [$];
  int                n_errors;
  int                comparisons;

  trc_core dut (.clk(clk), .rstn(rstn), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .io_req(io_req), .io_rdata(io_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
    .status_flags_reg(status_flags_reg));
  trc_mem_model mem_i (.clk(clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .io_req(io_req), .io_rdata(io_rdata));

  // clock and log of i/o writes
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) if (rstn && io_req.we) wq.push_back({io_req.addr, io_req.wdata});

  function automatic logic [15:0] load_constant(logic [3:0] r, logic [7:0] k); return {4'h8, r, k};
  endfunction : load_constant
  function automatic logic [15:0] iow(logic o, logic [4:0] r, logic [5:0] a);
    return {4'h9, o, r, a};
  endfunction : iow
  function automatic logic [15:0] misc(logic [4:0] r, logic [3:0] s);
    return {4'hc, 3'h0, r, s};
  endfunction : misc
  task automatic put(logic [15:0] w);
    mem_i.mem[pc] = w;
    pc++;
  endtask : put
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // programs: 0 alu and addressing, 1 return stack, 2 interrupts
  task automatic load(int p);
    foreach (mem_i.mem[i]) mem_i.mem[i] = 16'hc000;
    eq.delete();
    pc = 9'h000;
    if (p == 0) begin
      put({4'ha, 12'hffe});
      pc = 9'h1ff;
      put({4'ha, 12'h008});
      pc = 9'h008;
      foreach (ROWS[i]) begin
        put(load_constant(4'h0, ROWS[i].abr[23:16]));
        put(load_constant(4'h1, ROWS[i].abr[15:8]));
        put({ROWS[i].opc, ROWS[i].sub, 5'h10, 5'h11});
        put(iow(1'b1, 5'h10, 6'h10 + 6'(i)));
        eq.push_back({6'h10 + 6'(i), ROWS[i].abr[7:0]});
      end
      put(iow(1'b0, 5'h12, 6'h10));
      put(iow(1'b1, 5'h12, 6'h1f));
      put(load_constant(4'he, 8'h11));
      put(load_constant(4'hf, 8'hff));
      put(misc(5'h02, 4'h4));
      put(iow(1'b1, 5'h02, 6'h1e));
      put(load_constant(4'he, 8'hc1));
      put(load_constant(4'hf, 8'h01));
      put(misc(5'h00, 4'h3));
      put(iow(1'b1, 5'h00, 6'h1d));
      put({4'ha, 12'hfff});
      mem_i.mem[9'h0e0] = 16'h5aa5;
      eq.push_back({6'h1f, 8'h80});
      eq.push_back({6'h1e, 8'h5c});
      eq.push_back({6'h1d, 8'h5a});
    end else if (p == 1) begin
      for (int j = 0; j < 4; j++) begin
        mem_i.mem[4 * j] = {4'hb, 12'h003};
        mem_i.mem[4 * j + 1] = iow(1'b1, 5'h10, 6'h34 - 6'(j));
        mem_i.mem[4 * j + 2] = misc(5'h00, 4'h1);
      end
      mem_i.mem[16] = misc(5'h00, 4'h1);
      for (int j = 3; j > 0; j--) eq.push_back({6'h34 - 6'(j), 8'h00});
      eq.push_back({6'h33, 8'h00});
    end else begin
      put({4'ha, 12'h007});
      for (int v = 1; v < 6; v++) begin
        mem_i.mem[v] = {4'ha, 12'(63 + 3 * v)};
        mem_i.mem[64 + 4 * v] = iow(1'b1, 5'h10, 6'h20 + 6'(v));
        mem_i.mem[65 + 4 * v] = misc(5'h00, 4'h2);
      end
      mem_i.mem[8] = misc(5'h00, 4'h6);
      mem_i.mem[9] = {4'ha, 12'hfff};
      eq.push_back({6'h22, 8'h00});
      eq.push_back({6'h24, 8'h00});
    end
  endtask : load

  task automatic do_reset(int p);
    @(posedge clk);
    rstn <= 1'b0;
    load(p);
    repeat (12) @(posedge clk);
    check("reset fetch address", 16'(RESET_VEC), 16'(pmem_addr));
    check("reset status flags", 16'(STATUS_FLAGS_REG_RESET), 16'(status_flags_reg));
    wq.delete();
    rstn <= 1'b1;
  endtask : do_reset

  // waits for the expected i/o writes, then compares them in order
  task automatic collect(string name);
    int t;
    t = 0;
    while (wq.size() < eq.size() && t < 2000) begin
      @(posedge clk);
      t++;
    end
    foreach (eq[i]) check(name, 16'(eq[i]), (i < wq.size()) ? 16'(wq[i]) : 16'hffff);
    $display("test %s done", name);
  endtask : collect

  task automatic wait_ack(logic [IRQ_N-1:0] exp);
    int t;
    t = 0;
    @(posedge clk);
    while (irq_ack === 5'h00 && t < 200) begin
      @(posedge clk);
      t++;
    end
    check("interrupt ack", 16'(exp), 16'(irq_ack));
    check("global enable", 16'h0000, 16'(status_flags_reg[FLAG_I]));
  endtask : wait_ack

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    rstn = 1'b0;
    irq_req = 5'h00;
    n_errors = 0;
    comparisons = 0;
    do_reset(0);
    collect("alu rows and addressing");
    do_reset(1);
    collect("return stack");
    do_reset(2);
    irq_req <= 5'h0a;
    wait_ack(5'h02);
    irq_req <= 5'h08;
    wait_ack(5'h08);
    irq_req <= 5'h00;
    collect("interrupts");
    end_of_test();
  end

  // watchdog, far beyond the few hundred cycles the programs need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : tb_top
